// *** logic/cfg_checkfield_gen.sv ***
// Checkfield generator: pattern substitution over the active picture
`timescale 1ns/1ps
// Functional notes
// R01: Equalizer lines carry chroma 192.00 and luma 102.00.
// R02: From the transition line to the last active line, chroma 128.00 and luma 68.00.
// R03: Samples 0..3839 interleave Cb, Y, Cr, Y, giving 1920 luma samples.
// R04: Pattern starts on the first active line of each field (41/603, 45/670, 21/584, 42).
// R05: PLL pattern ends on the last active line (557/1120, 620/1245, 560/1123, 1121).
// R06: Last equalizer line lies within the per-format range; PLL begins the line after.
// R07: The chosen transition line is the same in every frame and field.
// R08: Every other frame, sample 1 of the first active line becomes 100.00.
// R09: Optional chroma/luma swap; then the polarity word is 128.00.
// R10: Active picture is 1035, 1152 or 1080 lines depending on format.
// R11: Equalizer codes are 300h chroma and 198h luma.
// R12: PLL codes are 200h chroma and 110h luma.
// R13: Polarity substitution turns luma 198h into 190h, one bit flipped.
// R14: Words outside the active picture pass through unchanged.
// R15: A frame-parity toggle advances once per frame and gates the polarity substitution.
module cfg_checkfield_gen #(
  parameter int WIDTH = 10,
  parameter int DEPTH = cfg_pkg::FIFO_DEPTH
) (
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  input  wire logic [1:0]       fmt,
  input  wire logic             swap_order,
  input  wire logic [3:0]       eq_offset,
  input  wire logic [10:0]      line_num,
  input  wire logic [11:0]      sample_num,
  input  wire logic             active,
  input  wire logic             frame_start,
  input  wire logic [WIDTH-1:0] in_word,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_word,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  // Line table and active heights must agree, or the pattern spills into blanking
  localparam int ACT_LINES [4] = '{cfg_pkg::ACT_1125I, cfg_pkg::ACT_1250I, cfg_pkg::ACT_CIF,
                                   cfg_pkg::ACT_CIF};
  initial
  begin
    if (WIDTH != 10) $error("cfg_checkfield_gen needs 10-bit words");
    for (int f = 0; f < 4; f++)
    begin
      if (int'(cfg_pkg::F1_LAST[f]) - int'(cfg_pkg::F1_FIRST[f]) + 1
          + ((f == 3) ? 0 : int'(cfg_pkg::F2_LAST[f]) - int'(cfg_pkg::F2_FIRST[f]) + 1)
          != ACT_LINES[f])
        $error("cfg_checkfield_gen line table disagrees with the active height"); // R10
      if (cfg_pkg::F1_EQ_HI[f] - cfg_pkg::F1_EQ_LO[f] != 11'(cfg_pkg::EQ_SPAN[f]))
        $error("cfg_checkfield_gen transition span disagrees with its range"); // R06
    end
  end

  // ---------------------------------------------------------------
  // Configuration latched per frame
  // ---------------------------------------------------------------
  // Latched only at frame start so the transition never moves mid-frame
  logic [1:0]  fmt_q;
  logic [1:0]  fmt_d;
  logic        swap_q;
  logic        swap_d;
  logic [3:0]  off_q;
  logic [3:0]  off_d;
  logic [3:0]  off_clip;

  always_comb
  begin
    off_clip = (eq_offset > cfg_pkg::EQ_SPAN[fmt]) ? cfg_pkg::EQ_SPAN[fmt] : eq_offset;
    fmt_d    = fmt_q;
    swap_d   = swap_q;
    off_d    = off_q;
    if (frame_start && in_valid && in_ready)
    begin
      fmt_d  = fmt;
      swap_d = swap_order;
      off_d  = off_clip; // R06 R07
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      fmt_q  <= cfg_pkg::FMT_CIFP;
      swap_q <= 1'b0;
      off_q  <= 4'h0;
    end
    else
    begin
      fmt_q  <= fmt_d;
      swap_q <= swap_d;
      off_q  <= off_d;
    end
  end

  // ---------------------------------------------------------------
  // Frame parity
  // ---------------------------------------------------------------
  logic pol_frame;
  logic take;
  assign take = in_valid && in_ready;

  cfg_frame_parity u_par (
    .sys_clk     (sys_clk),
    .rst_n       (rst_n),
    .frame_start (frame_start && take),
    .pol_frame   (pol_frame)
  );

  // ---------------------------------------------------------------
  // Region decode
  // ---------------------------------------------------------------
  cfg_pkg::cfg_region_t region;
  logic [10:0] eq_last1;
  logic [10:0] eq_last2;
  logic        interlaced;
  logic        first_line;

  always_comb
  begin
    interlaced = fmt_q != cfg_pkg::FMT_CIFP;
    eq_last1   = cfg_pkg::F1_EQ_LO[fmt_q] + 11'(off_q); // R06 R07
    eq_last2   = cfg_pkg::F2_EQ_LO[fmt_q] + 11'(off_q); // R07
    first_line = line_num == cfg_pkg::F1_FIRST[fmt_q];
    region     = cfg_pkg::CFG_RG_BLANK;
    if (line_num >= cfg_pkg::F1_FIRST[fmt_q] && line_num <= cfg_pkg::F1_LAST[fmt_q]) // R04 R05 R10
      region = (line_num <= eq_last1) ? cfg_pkg::CFG_RG_EQ : cfg_pkg::CFG_RG_PLL; // R06
    else if (interlaced && line_num >= cfg_pkg::F2_FIRST[fmt_q]
             && line_num <= cfg_pkg::F2_LAST[fmt_q]) // R04 R05 R10
      region = (line_num <= eq_last2) ? cfg_pkg::CFG_RG_EQ : cfg_pkg::CFG_RG_PLL; // R06
  end

  // ---------------------------------------------------------------
  // Word substitution
  // ---------------------------------------------------------------
  logic [9:0] chroma_v;
  logic [9:0] luma_v;
  logic [9:0] gen_word;
  logic       is_luma;
  logic       in_pic;
  logic       pol_hit;

  always_comb
  begin
    is_luma  = sample_num[0]; // R03
    in_pic   = active && sample_num <= cfg_pkg::LAST_SAMPLE && region != cfg_pkg::CFG_RG_BLANK;
    pol_hit  = pol_frame && first_line && sample_num == cfg_pkg::POL_SAMPLE; // R08 R15
    chroma_v = (region == cfg_pkg::CFG_RG_PLL) ? cfg_pkg::PLL_CHROMA : cfg_pkg::EQ_CHROMA; // R01 R02 R11 R12
    luma_v   = (region == cfg_pkg::CFG_RG_PLL) ? cfg_pkg::PLL_LUMA : cfg_pkg::EQ_LUMA; // R11 R12
    if (swap_q)
      gen_word = is_luma ? chroma_v : luma_v; // R09
    else
      gen_word = is_luma ? luma_v : chroma_v; // R03
    if (pol_hit)
      gen_word = swap_q ? cfg_pkg::POL_SWAPPED : cfg_pkg::POL_LUMA; // R08 R09 R13
    if (!in_pic)
      gen_word = in_word; // R14
  end

  // ---------------------------------------------------------------
  // Output register and buffer
  // ---------------------------------------------------------------
  // Register stage keeps the decode path out of the FIFO write port
  logic [9:0] word_q;
  logic [9:0] word_d;
  logic       vld_q;
  logic       vld_d;
  logic       stg_ready;

  assign in_ready = !vld_q || stg_ready;

  always_comb
  begin
    word_d = word_q;
    vld_d  = vld_q && !stg_ready;
    if (take)
    begin
      word_d = gen_word;
      vld_d  = 1'b1;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      word_q <= 10'h000;
      vld_q  <= 1'b0;
    end
    else
    begin
      word_q <= word_d;
      vld_q  <= vld_d;
    end
  end

  cfg_fifo #(
    .WIDTH (WIDTH),
    .DEPTH (DEPTH)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .in_data   (word_q),
    .in_valid  (vld_q),
    .in_ready  (stg_ready),
    .out_data  (out_word),
    .out_valid (out_valid),
    .out_ready (out_ready)
  );

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  property p_pass;
    @(posedge sys_clk) disable iff (!rst_n)
    take && !in_pic |=> word_q == $past(in_word);
  endproperty
  a_pass: assert property (p_pass) else $error("Blanking word altered"); // R14

  property p_eq_luma;
    @(posedge sys_clk) disable iff (!rst_n)
    take && in_pic && region == cfg_pkg::CFG_RG_EQ && is_luma && !swap_q && !pol_hit
      |=> word_q == 10'h198;
  endproperty
  a_eq_luma: assert property (p_eq_luma) else $error("Equalizer luma wrong"); // R01

  property p_eq_chroma;
    @(posedge sys_clk) disable iff (!rst_n)
    take && in_pic && region == cfg_pkg::CFG_RG_EQ && !is_luma && !swap_q |=> word_q == 10'h300;
  endproperty
  a_eq_chroma: assert property (p_eq_chroma) else $error("Equalizer chroma wrong"); // R11

  property p_pll;
    @(posedge sys_clk) disable iff (!rst_n)
    take && in_pic && region == cfg_pkg::CFG_RG_PLL && !swap_q
      |=> word_q == ($past(is_luma) ? 10'h110 : 10'h200);
  endproperty
  a_pll: assert property (p_pll) else $error("PLL word wrong"); // R02

  property p_pol;
    @(posedge sys_clk) disable iff (!rst_n)
    take && in_pic && pol_hit |=> word_q == ($past(swap_q) ? 10'h200 : 10'h190);
  endproperty
  a_pol: assert property (p_pol) else $error("Polarity word wrong"); // R08

  property p_after_last;
    @(posedge sys_clk) disable iff (!rst_n)
    line_num == cfg_pkg::F1_LAST[fmt_q] + 11'd1 && !interlaced |-> region == cfg_pkg::CFG_RG_BLANK;
  endproperty
  a_after_last: assert property (p_after_last) else $error("Pattern past last line"); // R05

  property p_trans;
    @(posedge sys_clk) disable iff (!rst_n)
    region == cfg_pkg::CFG_RG_PLL
      |-> (line_num > cfg_pkg::F1_EQ_LO[fmt_q] && line_num <= cfg_pkg::F1_LAST[fmt_q])
          || (interlaced && line_num > cfg_pkg::F2_EQ_LO[fmt_q]);
  endproperty
  a_trans: assert property (p_trans) else $error("PLL before range"); // R06

  property p_eq_range;
    @(posedge sys_clk) disable iff (!rst_n)
    region == cfg_pkg::CFG_RG_EQ
      |-> line_num <= cfg_pkg::F1_EQ_HI[fmt_q]
          || (interlaced && line_num >= cfg_pkg::F2_FIRST[fmt_q]
              && line_num <= cfg_pkg::F2_EQ_HI[fmt_q]);
  endproperty
  a_eq_range: assert property (p_eq_range) else $error("Equalizer past range"); // R06

  property p_stable;
    @(posedge sys_clk) disable iff (!rst_n)
    !(frame_start && take) |=> off_q == $past(off_q) && fmt_q == $past(fmt_q);
  endproperty
  a_stable: assert property (p_stable) else $error("Transition moved mid-frame"); // R07

  property p_swap;
    @(posedge sys_clk) disable iff (!rst_n)
    take && in_pic && swap_q && !pol_hit && is_luma && region == cfg_pkg::CFG_RG_EQ
      |=> word_q == 10'h300;
  endproperty
  a_swap: assert property (p_swap) else $error("Swapped order wrong"); // R09

  property p_swap_pll;
    @(posedge sys_clk) disable iff (!rst_n)
    take && in_pic && swap_q && region == cfg_pkg::CFG_RG_PLL
      |=> word_q == ($past(is_luma) ? 10'h200 : 10'h110);
  endproperty
  a_swap_pll: assert property (p_swap_pll) else $error("Swapped PLL word wrong"); // R09

  property p_tail;
    @(posedge sys_clk) disable iff (!rst_n)
    take && sample_num > cfg_pkg::LAST_SAMPLE |=> word_q == $past(in_word);
  endproperty
  a_tail: assert property (p_tail) else $error("Sample past line end altered"); // R03

  property p_pol_off;
    @(posedge sys_clk) disable iff (!rst_n)
    take && in_pic && first_line && sample_num == cfg_pkg::POL_SAMPLE && !pol_frame && !swap_q
      |=> word_q == 10'h198;
  endproperty
  a_pol_off: assert property (p_pol_off) else $error("Polarity word in wrong frame"); // R15

  c_pol: cover property (@(posedge sys_clk) take && in_pic && pol_hit);
  c_pll: cover property (@(posedge sys_clk) take && in_pic && region == cfg_pkg::CFG_RG_PLL);
  c_full: cover property (@(posedge sys_clk) !stg_ready);
  c_pol_swap: cover property (@(posedge sys_clk) take && in_pic && pol_hit && swap_q);
  c_field2: cover property (@(posedge sys_clk) take && in_pic && line_num >= cfg_pkg::F2_FIRST[fmt_q]
                            && interlaced);
endmodule

// *** logic/cfg_fifo.sv ***
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module cfg_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 16
) (
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  initial
  begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("cfg_fifo depth must be a power of two");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_q;
  logic [AW:0]      wr_d;
  logic [AW:0]      rd_q;
  logic [AW:0]      rd_d;
  logic             push;
  logic             pop;

  assign in_ready  = (wr_q - rd_q) != (AW+1)'(DEPTH);
  assign out_valid = wr_q != rd_q;
  assign out_data  = mem[rd_q[AW-1:0]];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb
  begin
    wr_d = wr_q + (AW+1)'(push);
    rd_d = rd_q + (AW+1)'(pop);
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      wr_q <= '0;
      rd_q <= '0;
    end
    else
    begin
      wr_q <= wr_d;
      rd_q <= rd_d;
    end
    if (push) mem[wr_q[AW-1:0]] <= in_data;
  end
endmodule

// *** logic/cfg_frame_parity.sv ***
// Frame parity toggle for the polarity control word
`timescale 1ns/1ps
module cfg_frame_parity (
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic frame_start,
  output logic      pol_frame
);
  logic par_q;
  logic par_d;

  always_comb
  begin
    par_d = frame_start ? !par_q : par_q; // R15
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n) par_q <= 1'b0;
    else par_q <= par_d;
  end

  assign pol_frame = par_q;

  property p_toggle;
    @(posedge sys_clk) disable iff (!rst_n)
    frame_start |=> pol_frame != $past(pol_frame);
  endproperty
  a_toggle: assert property (p_toggle) else $error("Parity did not toggle"); // R15
endmodule

// *** logic/cfg_pkg.sv ***
// Constants and types for the checkfield generator
package cfg_pkg;
  // ---------------------------------------------------------------
  // Sample codes
  // ---------------------------------------------------------------
  localparam logic [9:0] EQ_CHROMA   = 10'h300;
  localparam logic [9:0] EQ_LUMA     = 10'h198;
  localparam logic [9:0] PLL_CHROMA  = 10'h200;
  localparam logic [9:0] PLL_LUMA    = 10'h110;
  localparam logic [9:0] POL_LUMA    = 10'h190;
  localparam logic [9:0] POL_SWAPPED = 10'h200;
  // ---------------------------------------------------------------
  // Line and sample geometry
  // ---------------------------------------------------------------
  localparam logic [11:0] LAST_SAMPLE = 12'hEFF;
  localparam logic [11:0] POL_SAMPLE  = 12'h001;
  localparam int          ACT_1125I   = 1035;
  localparam int          ACT_1250I   = 1152;
  localparam int          ACT_CIF     = 1080;
  // Format codes
  localparam logic [1:0] FMT_1125I = 2'h0;
  localparam logic [1:0] FMT_1250I = 2'h1;
  localparam logic [1:0] FMT_CIFI  = 2'h2;
  localparam logic [1:0] FMT_CIFP  = 2'h3;
  // Per format: first line f1, first line f2, last line f1, last line f2,
  // equalizer end range low/high f1, low/high f2
  localparam logic [10:0] F1_FIRST [4] = '{11'd41, 11'd45, 11'd21, 11'd42};
  localparam logic [10:0] F2_FIRST [4] = '{11'd603, 11'd670, 11'd584, 11'd0};
  localparam logic [10:0] F1_LAST  [4] = '{11'd557, 11'd620, 11'd560, 11'd1121};
  localparam logic [10:0] F2_LAST  [4] = '{11'd1120, 11'd1245, 11'd1123, 11'd0};
  localparam logic [10:0] F1_EQ_LO [4] = '{11'd295, 11'd329, 11'd287, 11'd578};
  localparam logic [10:0] F1_EQ_HI [4] = '{11'd302, 11'd335, 11'd293, 11'd585};
  localparam logic [10:0] F2_EQ_LO [4] = '{11'd858, 11'd954, 11'd850, 11'd0};
  localparam logic [10:0] F2_EQ_HI [4] = '{11'd865, 11'd960, 11'd856, 11'd0};
  localparam logic [3:0]  EQ_SPAN  [4] = '{4'd7, 4'd6, 4'd6, 4'd7};
  // ---------------------------------------------------------------
  // Pattern region of the current line
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    CFG_RG_BLANK = 3'b001,
    CFG_RG_EQ    = 3'b010,
    CFG_RG_PLL   = 3'b100
  } cfg_region_t;
  localparam int FIFO_DEPTH = 16;
endpackage

// *** tb/cfg_checkfield_gen_tb.sv ***
// Self-checking bench for the checkfield generator
`timescale 1ns/1ps
`define CHK(a, b, m) begin cmp_count++; if ((a) !== (b)) begin fails++; $display("CHECK FAILED %0t %s", $time, m); end end
module cfg_checkfield_gen_tb;
  logic        sys_clk, rst_n, swap_order, active, frame_start, in_valid;
  logic        in_ready, out_valid, out_ready, par;
  logic [1:0]  fmt, mode;
  logic [3:0]  eq_offset;
  logic [10:0] line_num;
  logic [11:0] sample_num;
  logic [9:0]  in_word, out_word, keep;
  logic [9:0]  exp_q [$];
  int          fails, cmp_count, cycles;

  cfg_checkfield_gen u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .fmt(fmt),
    .swap_order(swap_order), .eq_offset(eq_offset), .line_num(line_num),
    .sample_num(sample_num), .active(active), .frame_start(frame_start),
    .in_word(in_word), .in_valid(in_valid), .in_ready(in_ready),
    .out_word(out_word), .out_valid(out_valid), .out_ready(out_ready));
  cfg_sink u_sink (.sys_clk(sys_clk), .rst_n(rst_n), .out_word(out_word),
    .out_valid(out_valid), .out_ready(out_ready), .mode(mode));

  // ---------------------------------------------------------------
  // Reference and drivers
  // ---------------------------------------------------------------
  function automatic logic [9:0] ref_word(input logic [10:0] l, input logic [11:0] s,
                                          input logic a, input logic [9:0] w);
    logic        f2;
    logic [10:0] lo;
    logic [3:0]  o;
    logic        eq;
    logic        in1;
    in1 = (l >= cfg_pkg::F1_FIRST[fmt]) && (l <= cfg_pkg::F1_LAST[fmt]);
    f2 = (fmt != 2'h3) && (l >= cfg_pkg::F2_FIRST[fmt]) && (l <= cfg_pkg::F2_LAST[fmt]);
    if (!a || s > 12'hEFF || !(in1 || f2)) return w;
    lo = f2 ? cfg_pkg::F2_EQ_LO[fmt] : cfg_pkg::F1_EQ_LO[fmt];
    o = (eq_offset > cfg_pkg::EQ_SPAN[fmt]) ? cfg_pkg::EQ_SPAN[fmt] : eq_offset;
    eq = l <= lo + {7'h00, o};
    if (par && !f2 && l == cfg_pkg::F1_FIRST[fmt] && s == 12'h001)
      return swap_order ? 10'h200 : 10'h190;
    if (s[0] ^ swap_order) return eq ? 10'h198 : 10'h110;
    return eq ? 10'h300 : 10'h200;
  endfunction

  task automatic send(input logic [10:0] l, input logic [11:0] s, input logic a, fs);
    logic ok;
    line_num = l;
    sample_num = s;
    active = a;
    frame_start = fs;
    in_word = a ? 10'h2AA : {s[5:0], l[3:0]};
    in_valid = 1'b1;
    exp_q.push_back(ref_word(l, s, a, in_word));
    if (fs) par = ~par;
    do
    begin
      @(negedge sys_clk);
      ok = in_ready;
      @(posedge sys_clk);
      #1;
    end while (!ok);
  endtask

  task automatic frame(input logic [1:0] f, input logic sw, input logic [3:0] off);
    logic [10:0] ln [8];
    logic [11:0] sm [4];
    logic [3:0]  o;
    exp_q.delete();
    u_sink.got.delete();
    fmt = f;
    swap_order = sw;
    eq_offset = off;
    o = (off > cfg_pkg::EQ_SPAN[f]) ? cfg_pkg::EQ_SPAN[f] : off;
    ln = '{cfg_pkg::F1_FIRST[f], cfg_pkg::F1_EQ_LO[f] + o, cfg_pkg::F1_EQ_LO[f] + o + 1,
           cfg_pkg::F1_LAST[f], cfg_pkg::F2_FIRST[f], cfg_pkg::F2_EQ_LO[f] + o,
           cfg_pkg::F2_EQ_LO[f] + o + 1, cfg_pkg::F2_LAST[f]};
    sm = '{12'h000, 12'h001, 12'h002, 12'hEFF};
    send(11'd1, 12'h000, 1'b0, 1'b1);
    for (int i = 0; i < ((f == 2'h3) ? 4 : 8); i++)
      for (int k = 0; k < 4; k++)
        send(ln[i], sm[k], 1'b1, 1'b0);
    send(ln[1], 12'h010, 1'b0, 1'b0);
    send(ln[0], 12'hF00, 1'b1, 1'b0);
    send(cfg_pkg::F1_LAST[f] + 11'd1, 12'h010, 1'b1, 1'b0);
    in_valid = 1'b0;
  endtask

  task automatic judge();
    int n;
    n = 0;
    while (u_sink.got.size() < exp_q.size() && n < 600)
    begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    `CHK(u_sink.got.size(), exp_q.size(), "word count")
    for (int i = 0; i < exp_q.size() && i < u_sink.got.size(); i++)
      `CHK(u_sink.got[i], exp_q[i], "word value")
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_formats();
    for (int f = 0; f < 4; f++)
    begin
      frame(f[1:0], 1'b0, 4'h3);
      judge();
    end
    $display("test formats done");
  endtask

  task automatic t_polarity();
    frame(2'h0, 1'b0, 4'h0);
    judge();
    keep = u_sink.got[2];
    `CHK(keep, 10'h190, "polarity word")
    frame(2'h0, 1'b0, 4'h0);
    judge();
    `CHK(u_sink.got[2], 10'h198, "no polarity word")
    `CHK(keep ^ u_sink.got[2], 10'h008, "one bit change")
    $display("test polarity done");
  endtask

  task automatic t_swap();
    frame(2'h2, 1'b1, 4'h5);
    judge();
    `CHK(u_sink.got[2], 10'h200, "swapped polarity")
    `CHK(u_sink.got[1], 10'h198, "swapped chroma slot")
    frame(2'h2, 1'b1, 4'h5);
    judge();
    `CHK(u_sink.got[2], 10'h300, "swapped luma slot")
    $display("test swap done");
  endtask

  task automatic t_clip();
    for (int r = 0; r < 2; r++)
    begin
      frame(2'h3, 1'b0, 4'hF);
      judge();
      `CHK(u_sink.got[6], 10'h198, "last equalizer line")
      `CHK(u_sink.got[10], 10'h110, "first pll line")
    end
    $display("test clip done");
  endtask

  task automatic t_backpressure();
    mode = 2'h2;
    fork
      frame(2'h1, 1'b0, 4'h2);
      begin
        repeat (40) @(posedge sys_clk);
        #2;
        `CHK(in_ready, 1'b0, "full buffer refuses")
        mode = 2'h1;
      end
    join
    judge();
    #2;
    `CHK(out_valid, 1'b0, "buffer drained")
    mode = 2'h0;
    $display("test backpressure done");
  endtask

  // ---------------------------------------------------------------
  // Clock, reset, timeout, verdict
  // ---------------------------------------------------------------
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // Ceiling well above the roughly 500 cycles the tests need
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 8000)
    begin
      fails++;
      close_out();
    end
  end

  initial
  begin
    {rst_n, swap_order, active, frame_start, in_valid, par} = '0;
    {fmt, mode, eq_offset, line_num, sample_num, in_word} = '0;
    {fails, cmp_count, cycles} = '0;
    repeat (4) @(posedge sys_clk);
    #1;
    rst_n = 1'b1;
    t_formats();
    t_polarity();
    t_swap();
    t_clip();
    t_backpressure();
    close_out();
  end
endmodule

// *** tb/cfg_sink.sv ***
// Receiver-side sink model that takes generator output words
`timescale 1ns/1ps
module cfg_sink (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic [9:0] out_word,
  input  wire logic       out_valid,
  output logic            out_ready,
  input  wire logic [1:0] mode
);
  logic [9:0] got [$];
  logic [3:0] cnt = 4'h0;
  // Mode 0 prompt, 1 slow (ready 6 cycles in 16), 2 stalled
  always @(posedge sys_clk)
  begin
    cnt <= cnt + 4'h1;
    out_ready <= #1 (mode == 2'h0) || (mode == 2'h1 && cnt % 3 == 0);
  end
  // Sampled mid-cycle: valid and ready hold until the taking edge
  always @(negedge sys_clk)
  begin
    if (rst_n && out_valid && out_ready)
    begin
      got.push_back(out_word);
    end
  end
endmodule
